// ### rtl/ibw_commit.v
// Write-cycle engine: walks the page buffer and writes each byte into
// the array, one byte per byte-write time, wrapping inside the page.
// Assumes go only arrives while busy is low and count is not zero.
module ibw_commit #(
  parameter [15:0] BYTE_CYC = 16'h0032
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Launch
  input  wire        go,
  input  wire [13:0] start_addr,
  input  wire [6:0]  count,
  input  wire [5:0]  page_mask,
  // Progress
  output reg         busy,
  output reg         wr_en,
  output reg  [13:0] wr_addr
);

  // ==================================================================
  // Byte walker
  reg  [15:0] tmr;
  reg  [6:0]  left;
  reg  [13:0] cur;
  wire [13:0] pm14     = {8'h00, page_mask};
  wire [13:0] cur_next = (cur & ~pm14) | ((cur + 14'h0001) & pm14);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy    <= 1'b0;
      wr_en   <= 1'b0;
      wr_addr <= 14'h0000;
      tmr     <= 16'h0000;
      left    <= 7'h00;
      cur     <= 14'h0000;
    end else begin
      wr_en <= 1'b0;
      if (go && !busy) begin
        busy <= 1'b1;
        cur  <= start_addr;
        left <= count;
        tmr  <= 16'h0000;
      end else if (busy) begin
        // Each byte costs one full byte-write time
        if (tmr == BYTE_CYC - 16'h0001) begin
          tmr     <= 16'h0000;
          wr_en   <= 1'b1;
          wr_addr <= cur;
          cur     <= cur_next;
          left    <= left - 7'h01;
          if (left == 7'h01) begin
            busy <= 1'b0;
          end
        end else begin
          tmr <= tmr + 16'h0001;
        end
      end
    end
  end

endmodule

// ### rtl/ibw_defs.vh
// Constants of the two-wire boot memory write slave: register offsets,
// field positions, reset values, address masks and timing counts.
// Assumes a 50 MHz core clock; included by its bare name.
`ifndef IBW_DEFS_VH
`define IBW_DEFS_VH

// ====================================================================
// Control byte
`define IBW_CLASS_CODE      4'hA

// ====================================================================
// Register offsets (byte addresses)
`define IBW_REG_CONFIG      12'h000
`define IBW_REG_STATUS      12'h004
`define IBW_REG_PEEK_ADDR   12'h008
`define IBW_REG_PEEK_DATA   12'h00C

// ====================================================================
// Config fields and reset value
`define IBW_CONFIG_RESET    2'h2
`define IBW_DENS_32K        2'h0
`define IBW_DENS_64K        2'h1

// Status fields
`define IBW_ST_BUSY         0
`define IBW_ST_POR          1
`define IBW_ST_WP           2
`define IBW_ST_PTR_LSB      16

// ====================================================================
// Address and page masks per density
`define IBW_AMASK_32K       14'h0FFF
`define IBW_AMASK_64K       14'h1FFF
`define IBW_AMASK_128K      14'h3FFF
`define IBW_PMASK_SMALL     6'h1F
`define IBW_PMASK_LARGE     6'h3F

// ====================================================================
// Timing
`define IBW_CLK_PERIOD_NS   20
`define IBW_POR_TIME_US     75
`define IBW_POR_CYCLES      ((`IBW_POR_TIME_US * 1000) / `IBW_CLK_PERIOD_NS)
`define IBW_BYTE_WRITE_NS   1000

`endif

// ### rtl/ibw_sync.v
// Two flip-flop synchroniser for a group of slow asynchronous levels.
// Assumes each bit changes far slower than core_clk; no bus coherence.
module ibw_sync #(
  parameter       W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input  wire         core_clk,
  input  wire         rst_n,
  // Levels
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  // ==================================================================
  // Stage one is read by stage two only
  reg [W-1:0] stage_one;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= RST_VAL;
      sync_out  <= RST_VAL;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule

// ### rtl/ibw_top.v
// Two-wire serial boot memory, write side: control byte decode, select
// pins, address bytes, page buffer, write protect and write cycle, with
// an APB slave for density setting, status and array inspection.
// Assumes open-drain data line resolved outside; scl slower than 1/6 clk.
`include "ibw_defs.vh"

// What this block does
// - Control byte upper nibble must match class
// - Select bits must equal three pin levels
// - Last control bit: one read, zero write
// - Matching control byte acknowledged on ninth pulse
// - Two address bytes acknowledged, then pointer loaded
// - Only STOP after data starts write cycle
// - No control acknowledge while write cycle runs
// - Pointer advances one, wrapping inside page
// - One command carries at most one page
// - Buffered bytes stored from given address onward
// - Buffer overflow overwrites earliest bytes
// - Pointer never crosses page boundary
// - Protected write acknowledged, no cycle, ready
// - Protected write still loads and advances pointer
// - Protect high at a write STOP blocks that command's array writes
// - Protect level sampled at each write STOP
// - Write time scales with byte count
// - Power-on reset lasts at most 75 us
// - START and STOP seen while clock high
// - Eight bits MSB first, then acknowledge
module ibw_top #(
  parameter BYTE_WRITE_NS = `IBW_BYTE_WRITE_NS
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Two-wire link
  input  wire        scl,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe_n,
  // Straps and protection
  input  wire        chip_select_pin_low,
  input  wire        chip_select_pin_mid,
  input  wire        chip_select_pin_high,
  input  wire        wp,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr
);

  // ==================================================================
  // Constants
  localparam [5:0]  PH_IDLE = 6'b000001;
  localparam [5:0]  PH_CTRL = 6'b000010;
  localparam [5:0]  PH_ADRH = 6'b000100;
  localparam [5:0]  PH_ADRL = 6'b001000;
  localparam [5:0]  PH_DATA = 6'b010000;
  localparam [5:0]  PH_SKIP = 6'b100000;
  localparam        POR_CYC_I  = `IBW_POR_CYCLES;
  localparam [11:0] POR_CYC    = POR_CYC_I[11:0];
  localparam        BYTE_CYC_I = BYTE_WRITE_NS / `IBW_CLK_PERIOD_NS;
  localparam [15:0] BYTE_CYC = (BYTE_CYC_I < 1) ? 16'h0001 : BYTE_CYC_I[15:0];

  // ==================================================================
  // Storage: the array and the page buffer
  reg  [7:0]  mem [0:16383];
  reg  [7:0]  page_buf [0:63];

  // ==================================================================
  // Synchronised inputs; second flop outputs only
  wire        scl_s;
  wire        sda_s;
  wire        wp_s;
  wire [2:0]  sel_s;

  ibw_sync #(.W(2), .RST_VAL(2'h3)) u_link_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({scl, sda_in}),
    .sync_out ({scl_s, sda_s})
  );

  ibw_sync #(.W(4), .RST_VAL(4'h0)) u_pin_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({wp, chip_select_pin_high, chip_select_pin_mid, chip_select_pin_low}),
    .sync_out ({wp_s, sel_s})
  );

  // ==================================================================
  // State
  reg         scl_d;
  reg         sda_d;
  reg  [5:0]  phase;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  shreg;
  reg  [7:0]  addr_hi;
  reg  [13:0] ptr;
  reg  [13:0] wr_base;
  reg  [5:0]  rcv_cnt;
  reg         ovf;
  reg         have_data;
  reg         wp_lat;
  reg         commit_go;
  reg  [11:0] por_cnt;
  reg         por_active;
  reg  [1:0]  cfg_density;
  reg  [13:0] peek_addr;

  wire        busy;
  wire        mem_we;
  wire [13:0] mem_waddr;

  // ==================================================================
  // Bus events
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;
  wire listen   = (phase != PH_IDLE) && (phase != PH_SKIP);
  wire byte_end = listen && scl_fall && (bit_cnt == 4'h8);

  // ==================================================================
  // Density decode: address range and page size
  reg  [13:0] amask;
  reg  [5:0]  pmask;

  always @* begin
    case (cfg_density)
      `IBW_DENS_32K: begin
        amask = `IBW_AMASK_32K;
        pmask = `IBW_PMASK_SMALL;
      end
      `IBW_DENS_64K: begin
        amask = `IBW_AMASK_64K;
        pmask = `IBW_PMASK_SMALL;
      end
      default: begin
        amask = `IBW_AMASK_128K;
        pmask = `IBW_PMASK_LARGE;
      end
    endcase
  end

  // ==================================================================
  // Page arithmetic
  wire [13:0] pm14      = {8'h00, pmask};
  wire [5:0]  buf_idx   = (wr_base[5:0] & ~pmask) | ((wr_base[5:0] + rcv_cnt) & pmask);
  wire [5:0]  rcv_next  = (rcv_cnt + 6'h01) & pmask;
  wire [13:0] ptr_adv   = (ptr & ~pm14) | ((ptr + {8'h00, rcv_cnt}) & pm14);
  wire [6:0]  commit_n  = ovf ? ({1'b0, pmask} + 7'h01) : {1'b0, rcv_cnt};
  wire        sel_match = (shreg[7:4] == `IBW_CLASS_CODE) && (shreg[3:1] == sel_s);

  // ==================================================================
  // Power-on hold-off after reset release
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt    <= 12'h000;
      por_active <= 1'b1;
    end else if (por_active) begin
      // Longest time rounds down, so the hold-off never overruns
      if (por_cnt == POR_CYC - 12'h001) begin
        por_active <= 1'b0;
      end
      por_cnt <= por_cnt + 12'h001;
    end
  end

  // ==================================================================
  // Link sequencer
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d     <= 1'b1;
      sda_d     <= 1'b1;
      sda_out   <= 1'b0;
      sda_oe_n  <= 1'b1;
      phase     <= PH_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      addr_hi   <= 8'h00;
      ptr       <= 14'h0000;
      wr_base   <= 14'h0000;
      rcv_cnt   <= 6'h00;
      ovf       <= 1'b0;
      have_data <= 1'b0;
      wp_lat    <= 1'b0;
      commit_go <= 1'b0;
    end else begin
      scl_d     <= scl_s;
      sda_d     <= sda_s;
      commit_go <= 1'b0;
      if (por_active) begin
        // Bus is ignored until the power-on hold-off ends
        phase    <= PH_IDLE;
        sda_oe_n <= 1'b1;
      end else if (start_c) begin
        phase    <= PH_CTRL;
        bit_cnt  <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_c) begin
        sda_oe_n <= 1'b1;
        phase    <= PH_IDLE;
        // Data without this STOP is never committed
        if ((phase == PH_DATA) && have_data) begin
          wp_lat    <= wp_s;
          ptr       <= ptr_adv;
          commit_go <= ~wp_s;
          have_data <= 1'b0;
        end
      end else begin
        if (listen && scl_rise && (bit_cnt < 4'h8)) begin
          shreg   <= {shreg[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (byte_end) begin
          bit_cnt <= 4'h9;
          case (phase)
            PH_CTRL: begin
              // Busy device stays silent so the master can poll
              if (sel_match && !busy) begin
                sda_oe_n <= 1'b0;
                phase    <= shreg[0] ? PH_SKIP : PH_ADRH;
              end else begin
                phase <= PH_SKIP;
              end
            end
            PH_ADRH: begin
              sda_oe_n <= 1'b0;
              addr_hi  <= shreg;
              phase    <= PH_ADRL;
            end
            PH_ADRL: begin
              sda_oe_n  <= 1'b0;
              ptr       <= {addr_hi[5:0], shreg} & amask;
              wr_base   <= {addr_hi[5:0], shreg} & amask;
              rcv_cnt   <= 6'h00;
              ovf       <= 1'b0;
              have_data <= 1'b0;
              phase     <= PH_DATA;
            end
            PH_DATA: begin
              sda_oe_n  <= 1'b0;
              rcv_cnt   <= rcv_next;
              have_data <= 1'b1;
              if (rcv_cnt == pmask) begin
                ovf <= 1'b1;
              end
            end
            default: begin
              phase <= PH_SKIP;
            end
          endcase
        end else if (scl_fall && (bit_cnt == 4'h9)) begin
          // Acknowledge slot over: let go of the line
          sda_oe_n <= 1'b1;
          bit_cnt  <= 4'h0;
        end
      end
    end
  end

  // ==================================================================
  // Page buffer fill; index wraps inside the page
  always @(posedge core_clk) begin
    if (!por_active && !start_c && !stop_c && byte_end && (phase == PH_DATA)) begin
      page_buf[buf_idx] <= shreg;
    end
  end

  // ==================================================================
  // Write cycle
  ibw_commit #(.BYTE_CYC(BYTE_CYC)) u_commit (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .go         (commit_go),
    .start_addr (wr_base),
    .count      (commit_n),
    .page_mask  (pmask),
    .busy       (busy),
    .wr_en      (mem_we),
    .wr_addr    (mem_waddr)
  );

  // Buffer slot follows the address low bits, so no separate index
  always @(posedge core_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= page_buf[mem_waddr[5:0]];
    end
  end

  // ==================================================================
  // APB slave: one wait-free access, pready from a flop
  reg  [31:0] rd_mux;
  reg         addr_hit;

  always @* begin
    rd_mux   = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr)
      `IBW_REG_CONFIG: begin
        rd_mux = {30'h0000_0000, cfg_density};
      end
      `IBW_REG_STATUS: begin
        rd_mux[`IBW_ST_BUSY]                      = busy;
        rd_mux[`IBW_ST_POR]                       = por_active;
        rd_mux[`IBW_ST_WP]                        = wp_lat;
        rd_mux[`IBW_ST_PTR_LSB+13:`IBW_ST_PTR_LSB] = ptr;
      end
      `IBW_REG_PEEK_ADDR: begin
        rd_mux = {18'h0_0000, peek_addr};
      end
      `IBW_REG_PEEK_DATA: begin
        rd_mux = {24'h00_0000, mem[peek_addr]};
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      cfg_density <= `IBW_CONFIG_RESET;
      peek_addr   <= 14'h0000;
    end else begin
      if (psel && !penable) begin
        pready  <= 1'b1;
        pslverr <= ~addr_hit;
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
      // Writes take effect only at the completing edge
      if (psel && penable && pready && pwrite) begin
        if (paddr == `IBW_REG_CONFIG) begin
          cfg_density <= pwdata[1:0];
        end
        if (paddr == `IBW_REG_PEEK_ADDR) begin
          peek_addr <= pwdata[13:0];
        end
      end
    end
  end

endmodule

// ### testbench/ibw_master.sv
// Two-wire bus master model paced by core_clk; scl period 8 cycles.
// Assumes a pull-up on the data line, resolved by the bench.
module ibw_master (
  // Pacing clock
  input  wire logic clk,
  // Link
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // ==================================================================
  // Conditions and bits
  task automatic start_cond();
    @(posedge clk) sda_drv <= 1'b1;
    repeat (4) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda_drv <= 1'b0;
    repeat (3) @(posedge clk);
    scl <= 1'b0;
  endtask

  task automatic stop_cond();
    @(posedge clk) sda_drv <= 1'b0;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda_drv <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // Data only moves while the clock is low
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk) sda_drv <= b;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    r = sda_line;
    @(posedge clk) scl <= 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
endmodule

// ### testbench/ibw_top_props.sv
// Checker for the two-wire boot memory write slave, on top-level ports.
// Assumes one core_clk domain; the link is sampled raw, ahead of the device's two-flop synchroniser.
module ibw_top_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Link
  input wire logic        scl,
  input wire logic        sda_in,
  input wire logic        sda_oe_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR_CYC = 3750;
  logic [11:0] por_cnt;
  logic [3:0]  bit_cnt;
  logic        scl_q;
  logic        sda_q;
  wire         start_ev = scl && scl_q && sda_q && !sda_in;

  // ==================================================================
  // Hold-off counter and bit position since START
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt <= 12'h000;
      bit_cnt <= 4'h0;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      if (por_cnt != 12'hFFF) begin
        por_cnt <= por_cnt + 12'h001;
      end
      if (start_ev) begin
        bit_cnt <= 4'h0;
      end else if (scl && !scl_q) begin
        bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      end
    end
  end

  // ==================================================================
  // Properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_ack_hold;
    !sda_oe_n [*7] ##[1:3] sda_oe_n;
  endsequence
  property p_por_quiet; por_cnt < POR_CYC |-> sda_oe_n; endproperty
  property p_ack_ninth; $fell(sda_oe_n) |-> bit_cnt == 4'h8 && !scl; endproperty
  property p_ack_hold; $fell(sda_oe_n) |-> s_ack_hold; endproperty
  property p_ack_release; $rose(sda_oe_n) |-> !scl; endproperty
  property p_start_quiet; start_ev |-> sda_oe_n [*3]; endproperty
  property p_apb_ready; psel && !penable |=> pready; endproperty
  property p_apb_pulse; pready |=> !pready; endproperty
  property p_apb_err; psel && !penable && paddr > 12'h00C |=> pslverr && prdata == 32'h0000_0000; endproperty
  property p_apb_ok; psel && !penable && paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0 |=> !pslverr; endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("ack in hold-off");
  a_ack_ninth: assert property (p_ack_ninth) else $error("ack off ninth bit");
  a_ack_hold: assert property (p_ack_hold) else $error("ack length wrong");
  a_ack_release: assert property (p_ack_release) else $error("ack released with clock high");
  a_start_quiet: assert property (p_start_quiet) else $error("line held at START");
  a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
  a_apb_pulse: assert property (p_apb_pulse) else $error("ready too long");
  a_apb_err: assert property (p_apb_err) else $error("unmapped not refused");
  a_apb_ok: assert property (p_apb_ok) else $error("mapped refused");
endmodule

bind ibw_top ibw_top_chk u_chk (.core_clk, .rst_n, .scl, .sda_in, .sda_oe_n, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr);

// ### testbench/ibw_top_tb.sv
// Bench for the boot memory write slave: APB tasks and a two-wire master.
// Assumes 50 MHz core_clk, 160 ns scl and 200 cycles per byte write.
`include "ibw_defs.vh"

module ibw_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTRL_W = 8'hAA;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        wp       = 1'b0;
  logic [2:0]  pins     = 3'h5;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic        pready;
  logic        pslverr;
  logic        sda_out;
  logic        sda_oe_n;
  logic        scl;
  logic        sda_drv;
  logic        lerr;
  logic        k;
  int          n;
  int          cyc      = 0;
  int          busy_len;
  int          fails    = 0;
  int          total_checks = 0;
  wire         sda_line = sda_drv & (sda_oe_n | sda_out);

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  ibw_top #(.BYTE_WRITE_NS(4000)) dut (.core_clk, .rst_n, .scl, .sda_in(sda_line), .sda_out, .sda_oe_n,
    .chip_select_pin_low(pins[0]), .chip_select_pin_mid(pins[1]), .chip_select_pin_high(pins[2]), .wp,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  ibw_master mst (.clk(core_clk), .scl, .sda_drv, .sda_line);

  // ==================================================================
  // Reporting
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  // ==================================================================
  // APB master: request stands until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      t++;
    end while (pready !== 1'b1 && t < 16);
    rdat = prdata;
    lerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic chk_mem(input logic [13:0] a, input logic [7:0] e);
    apb(1'b1, `IBW_REG_PEEK_ADDR, {18'h0_0000, a});
    rd(`IBW_REG_PEEK_DATA);
    chk_word("array byte", {24'h00_0000, e}, rdat);
  endtask

  task automatic chk_ptr(input logic [13:0] e);
    rd(`IBW_REG_STATUS);
    chk_word("pointer", {18'h0_0000, e}, {18'h0_0000, rdat[29:16]});
  endtask

  // Busy is polled over APB; its length is kept for timing checks
  task automatic wait_idle();
    int t0 = cyc;
    do rd(`IBW_REG_STATUS); while (rdat[0] !== 1'b0 && cyc - t0 < 30000);
    busy_len = cyc - t0;
    if (rdat[0] !== 1'b0) begin
      fails++;
      complete_run();
    end
  endtask

  // Write command without its STOP; upper address bits sent as zero
  task automatic wcmd(input logic [13:0] a, input int cnt, input logic [7:0] b);
    logic ak;
    mst.start_cond();
    mst.byte_io(CTRL_W, ak);
    chk_bit("ctrl ack", 1'b1, ak);
    mst.byte_io({2'b00, a[13:8]}, ak);
    chk_bit("addr hi ack", 1'b1, ak);
    mst.byte_io(a[7:0], ak);
    chk_bit("addr lo ack", 1'b1, ak);
    for (int i = 0; i < cnt; i++) begin
      mst.byte_io(b + i[7:0], ak);
      chk_bit("data ack", 1'b1, ak);
    end
  endtask

  // ==================================================================
  // Tests
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`IBW_REG_CONFIG);
    chk_word("config reset", {30'h0000_0000, `IBW_CONFIG_RESET}, rdat);
    rd(`IBW_REG_STATUS);
    chk_bit("hold-off flag", 1'b1, rdat[1]);
    mst.start_cond();
    mst.byte_io(CTRL_W, k);
    chk_bit("ack in hold-off", 1'b0, k);
    mst.stop_cond();
    rd(12'h010);
    chk_bit("slave error", 1'b1, lerr);
    chk_word("unmapped data", 32'h0000_0000, rdat);
    repeat (3760) @(posedge core_clk);
    rd(`IBW_REG_STATUS);
    chk_bit("hold-off flag", 1'b0, rdat[1]);
    $display("test reset done");
    for (int s = 0; s < 8; s++) begin
      mst.start_cond();
      mst.byte_io({4'hA, s[2:0], 1'b0}, k);
      chk_bit("select ack", s == 5, k);
      mst.stop_cond();
    end
    mst.start_cond();
    mst.byte_io(8'hBA, k);
    chk_bit("class ack", 1'b0, k);
    mst.byte_io(8'h00, k);
    chk_bit("ignored byte ack", 1'b0, k);
    mst.start_cond();
    mst.byte_io(8'hAB, k);
    chk_bit("read ctrl ack", 1'b1, k);
    mst.stop_cond();
    $display("test select done");
    wcmd(14'h003F, 1, 8'h5A);
    mst.stop_cond();
    n = 0;
    do begin
      mst.start_cond();
      mst.byte_io(CTRL_W, k);
      mst.stop_cond();
      n++;
    end while (!k && n < 20);
    chk_bit("poll refused", 1'b1, n > 1);
    chk_bit("poll acked", 1'b1, k);
    if (!k) complete_run();
    chk_mem(14'h003F, 8'h5A);
    chk_ptr(14'h0000);
    $display("test byte write done");
    wcmd(14'h087A, 66, 8'h00);
    mst.stop_cond();
    wait_idle();
    chk_mem(14'h087A, 8'h40);
    chk_mem(14'h087B, 8'h41);
    chk_mem(14'h0840, 8'h06);
    chk_mem(14'h0843, 8'h09);
    chk_ptr(14'h087C);
    $display("test page write done");
    apb(1'b1, `IBW_REG_CONFIG, 32'h0000_0000);
    rd(`IBW_REG_CONFIG);
    chk_word("config", 32'h0000_0000, rdat);
    wcmd(14'h0FFE, 3, 8'h20);
    mst.stop_cond();
    wait_idle();
    chk_bit("busy length", 1'b1, busy_len >= 585 && busy_len <= 620);
    chk_mem(14'h0FE0, 8'h22);
    chk_ptr(14'h0FE1);
    apb(1'b1, `IBW_REG_CONFIG, 32'h0000_0001);
    wcmd(14'h1FFF, 1, 8'h77);
    mst.stop_cond();
    wait_idle();
    chk_mem(14'h1FFF, 8'h77);
    chk_ptr(14'h1FE0);
    apb(1'b1, `IBW_REG_CONFIG, 32'h0000_0002);
    $display("test small page done");
    wp <= 1'b1;
    wcmd(14'h0842, 2, 8'hC0);
    mst.stop_cond();
    wp <= 1'b0;
    rd(`IBW_REG_STATUS);
    chk_word("status", 32'h0844_0004, rdat);
    mst.start_cond();
    mst.byte_io(CTRL_W, k);
    chk_bit("ready after protect", 1'b1, k);
    mst.stop_cond();
    chk_mem(14'h0843, 8'h09);
    $display("test protect done");
    wcmd(14'h0840, 1, 8'hEE);
    mst.start_cond();
    mst.byte_io(CTRL_W, k);
    mst.stop_cond();
    rd(`IBW_REG_STATUS);
    chk_bit("busy", 1'b0, rdat[0]);
    chk_mem(14'h0840, 8'h06);
    $display("test no stop done");
    pins <= 3'h2;
    repeat (4) @(posedge core_clk);
    mst.start_cond();
    mst.byte_io(8'hA4, k);
    chk_bit("moved select ack", 1'b1, k);
    mst.stop_cond();
    $display("test pins done");
    complete_run();
  end
endmodule
